/* File: hw/button_sense.sv */
// push-button level and edge capture
`timescale 1ns/1ps
`default_nettype none
module button_sense (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic push_button_in_n_i,
    input wire logic push_button_hard_n_i,
    output logic pressed_o,
    output logic hard_o,
    output logic rise_o,
    output logic fall_o
);
    import pmu_pkg::*;

    button_state_t q, d;

    // the low-impedance comparator only counts while the pin is asserted
    always_comb begin
        d.pressed = ~push_button_in_n_i;
        d.hard = ~push_button_in_n_i & ~push_button_hard_n_i;
        d.rise = ~push_button_in_n_i & ~q.pressed;
        d.fall = push_button_in_n_i & q.pressed;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pressed_o = q.pressed;
    assign hard_o = q.hard;
    assign rise_o = q.rise;
    assign fall_o = q.fall;
endmodule
`default_nettype wire

/* File: hw/ms_tick.sv */
// one-millisecond enable pulse from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "pmu_consts.svh"
module ms_tick #(
    parameter int TICK_CYCLES = `PMU_TICK_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    output logic tick_o
);
    import pmu_pkg::*;

    tick_state_t q, d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == 16'(TICK_CYCLES - 1)) begin
            d.cnt = 16'h0000;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;
endmodule
`default_nettype wire

/* File: hw/pmu_consts.svh */
// constants of the push-button power mode control block
`ifndef PMU_CONSTS_SVH
`define PMU_CONSTS_SVH

// ======================================================
// timebase
`define PMU_CLK_KHZ 40000
`define PMU_TICK_MS 1
`define PMU_TICK_CYCLES (`PMU_CLK_KHZ * `PMU_TICK_MS)

// ======================================================
// sequence delays after rail two is good, in ms
`define PMU_RAIL3_MS 8'h02
`define PMU_RAIL1_MS 8'h04
`define PMU_RAIL5_MS 8'h08
`define PMU_RST_TIMEOUT_MS 8'h40
`define PMU_MS_MAX 8'hff

// ======================================================
// register map, byte addresses
`define PMU_CTRL_OFS 8'h00
`define PMU_STAT_OFS 8'h04

// ======================================================
// control fields
`define PMU_CTRL_RESET 5'h00
`define PMU_CTRL_FRC1 0
`define PMU_CTRL_R6 1
`define PMU_CTRL_R7 2
`define PMU_CTRL_SYSMSK 3
`define PMU_CTRL_FLTMSK 4
`define PMU_CTRL_W 5

// ======================================================
// rail masks
`define PMU_RAILS_OFF 7'h00
`define PMU_RAILS_ALL 7'h7f
`define PMU_RAILS_NORMAL 7'h1f
`define PMU_RAILS_ONE 7'h01

`endif

/* File: hw/pmu_pkg.sv */
// types of the push-button power mode control block
package pmu_pkg;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_SEQ = 2'b01,
        ST_RUN = 2'b10
    } pmu_mode_t;

    typedef struct packed {
        pmu_mode_t st;
        logic [7:0] ms;
        logic [7:0] rst_ms;
        logic man;
        logic [6:0] rails;
        logic rst_oe;
        logic stat_oe;
        logic irq_oe;
        logic [4:0] ctrl;
        logic ack;
        logic [31:0] rdat;
    } pmu_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } tick_state_t;

    typedef struct packed {
        logic pressed;
        logic hard;
        logic rise;
        logic fall;
    } button_state_t;

endpackage

/* File: hw/pushbutton_power_mode_control.sv */
// push-button power mode control: rail enables, processor reset, status and interrupt pins
// ======================================================
`timescale 1ns/1ps
`default_nettype none
`include "pmu_consts.svh"
module pushbutton_power_mode_control #(
    parameter int TICK_CYCLES = `PMU_TICK_CYCLES,
    parameter logic [7:0] RESET_TIMEOUT_MS = `PMU_RST_TIMEOUT_MS
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic push_button_in_n_i,
    input wire logic push_button_hard_n_i,
    input wire logic power_hold_i,
    input wire logic hibernate_in_n_i,
    input wire logic rail_two_good_i,
    input wire logic rail_fault_i,
    input wire logic sys_voltage_low_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [6:0] rail_en_o,
    output logic processor_reset_out_n_o,
    output logic processor_reset_out_n_oe_o,
    output logic button_status_out_n_o,
    output logic button_status_out_n_oe_o,
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe_o
);
    import pmu_pkg::*;

    // ======================================================
    // helpers
    logic tick;
    logic pressed;
    logic hard;
    logic press_rise;
    logic press_fall;
    logic takeover;
    logic force_one;
    pmu_state_t q, d;

    ms_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // two comparators on the pin separate the two press kinds
    button_sense u_button (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .push_button_in_n_i(push_button_in_n_i),
        .push_button_hard_n_i(push_button_hard_n_i),
        .pressed_o(pressed),
        .hard_o(hard),
        .rise_o(press_rise),
        .fall_o(press_fall)
    );

    assign takeover = power_hold_i & hibernate_in_n_i;
    assign force_one = q.ctrl[`PMU_CTRL_FRC1];

    // ======================================================
    // next state
    always_comb begin
        d = q;

        // wishbone slave: one wait state, unmapped reads return zero
        d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
        if (d.ack) begin
            d.rdat = 32'h0000_0000;
            if (wb_adr_i == `PMU_CTRL_OFS) begin
                d.rdat = {27'h000_0000, q.ctrl};
                if (wb_we_i && wb_sel_i[0]) begin
                    d.ctrl = wb_dat_i[`PMU_CTRL_W-1:0];
                end
            end else if (wb_adr_i == `PMU_STAT_OFS) begin
                d.rdat = {19'h0_0000, q.st, rail_fault_i, rail_two_good_i, sys_voltage_low_i, ~q.rst_oe, q.rails};
            end
        end

        // mode transitions
        case (q.st)
            ST_OFF: begin
                if (press_rise) begin
                    d.st = ST_SEQ;
                end
            end
            ST_SEQ: begin
                if (press_fall) begin
                    // release before takeover aborts the start
                    d.st = takeover ? ST_RUN : ST_OFF;
                end
            end
            ST_RUN: begin
                if (press_rise && !hibernate_in_n_i) begin
                    d.st = ST_SEQ; // wake from hibernate
                end else if (!power_hold_i && !hibernate_in_n_i && !force_one) begin
                    d.st = ST_OFF;
                end
            end
            default: begin
                d.st = ST_OFF;
            end
        endcase

        // time since rail two good, saturating
        if (d.st != ST_SEQ || !rail_two_good_i) begin
            d.ms = 8'h00;
        end else if (tick && q.ms != `PMU_MS_MAX) begin
            d.ms = q.ms + 8'h01;
        end

        // rail enables follow the next mode
        case (d.st)
            ST_SEQ: begin
                d.rails[1] = 1'b1;
                d.rails[3] = rail_two_good_i;
                d.rails[2] = rail_two_good_i && q.ms >= `PMU_RAIL3_MS;
                d.rails[0] = (rail_two_good_i && q.ms >= `PMU_RAIL1_MS) || power_hold_i || force_one;
                d.rails[4] = rail_two_good_i && q.ms >= `PMU_RAIL5_MS;
                d.rails[6:5] = 2'b00;
            end
            ST_RUN: begin
                d.rails[0] = power_hold_i | force_one;
                d.rails[4:1] = {4{hibernate_in_n_i}};
                d.rails[5] = q.ctrl[`PMU_CTRL_R6] & hibernate_in_n_i;
                d.rails[6] = q.ctrl[`PMU_CTRL_R7] & hibernate_in_n_i;
            end
            default: begin
                d.rails = `PMU_RAILS_OFF;
            end
        endcase

        // manual reset: held while pressed, then timed after release
        if (hard) begin
            d.man = 1'b1;
            d.rst_ms = 8'h00;
        end else if (q.man && !pressed) begin
            if (q.rst_ms >= RESET_TIMEOUT_MS) begin
                d.man = 1'b0;
            end else if (tick) begin
                d.rst_ms = q.rst_ms + 8'h01;
            end
        end

        // startup reset released only after timeout from rail two good
        d.rst_oe = d.man || d.st == ST_OFF || (d.st == ST_SEQ && !(rail_two_good_i && q.ms >= RESET_TIMEOUT_MS));

        d.stat_oe = pressed;
        d.irq_oe = (sys_voltage_low_i & q.ctrl[`PMU_CTRL_SYSMSK])
                 | (rail_fault_i & q.ctrl[`PMU_CTRL_FLTMSK]);
    end

    // ======================================================
    // state register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= ST_OFF;
            q.ctrl <= `PMU_CTRL_RESET;
            q.rst_oe <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ======================================================
    // outputs, open-drain pins only ever pull low
    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;
    assign rail_en_o = q.rails;
    assign processor_reset_out_n_o = 1'b0;
    assign processor_reset_out_n_oe_o = q.rst_oe;
    assign button_status_out_n_o = 1'b0;
    assign button_status_out_n_oe_o = q.stat_oe;
    assign interrupt_out_n_o = 1'b0;
    assign interrupt_out_n_oe_o = q.irq_oe;

    // ======================================================
    // assertions
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    a_all_on: assert property ((q.st == ST_RUN && takeover && q.ctrl[2:1] == 2'b11 && !press_rise)
        |=> rail_en_o == `PMU_RAILS_ALL) else $error("all-on mode rails wrong");
    a_normal_mode: assert property ((q.st == ST_RUN && takeover && q.ctrl[2:1] == 2'b00 && !press_rise)
        |=> rail_en_o == `PMU_RAILS_NORMAL) else $error("normal mode rails wrong");
    a_hibernate_rails: assert property ((q.st == ST_RUN && power_hold_i && !hibernate_in_n_i && force_one && !press_rise)
        |=> rail_en_o == `PMU_RAILS_ONE) else $error("hibernate rails wrong");
    a_all_off: assert property ((!power_hold_i && !hibernate_in_n_i && !force_one && q.st != ST_SEQ && !press_rise)
        |=> rail_en_o == `PMU_RAILS_OFF) else $error("rails not off");
    a_manual_reset: assert property (hard |=> processor_reset_out_n_oe_o [*2])
        else $error("manual reset not held");
    a_button_status: assert property (pressed |=> button_status_out_n_oe_o)
        else $error("status pin not pulled");
    a_status_release: assert property (!pressed |=> !button_status_out_n_oe_o)
        else $error("status pin held without press");
    a_startup_reset: assert property ((q.st == ST_SEQ && !rail_two_good_i) |=> processor_reset_out_n_oe_o)
        else $error("reset released before rail two good");
    a_irq_masked: assert property (interrupt_out_n_oe_o |-> $past(q.ctrl[4:3]) != 2'b00)
        else $error("masked interrupt reached pin");
    a_seq_abort: assert property ((q.st == ST_SEQ && press_fall && !takeover)
        |=> q.st == ST_OFF && rail_en_o == `PMU_RAILS_OFF) else $error("abort did not shut down");
    a_seq_start: assert property ((q.st == ST_OFF && press_rise) |=> rail_en_o[1] && q.st == ST_SEQ)
        else $error("press did not start sequence");
    a_rail_order: assert property ((q.st == ST_SEQ && rail_en_o[2]) |-> rail_en_o[3] && rail_en_o[1])
        else $error("rail three before rail four");

    c_takeover: cover property (q.st == ST_SEQ ##1 q.st == ST_RUN);
    c_abort: cover property (q.st == ST_SEQ ##1 q.st == ST_OFF);
    c_hibernate: cover property (q.st == ST_RUN && rail_en_o == `PMU_RAILS_ONE);
    c_manual_done: cover property (q.man ##1 !q.man);
endmodule
`default_nettype wire

/* File: testbench/proc_button_model.sv */
// processor and push-button model at the far side of the power control block
`timescale 1ns/1ps
`default_nettype none
module proc_button_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [6:0] rail_en_i,
    input wire logic reset_oe_i,
    input wire logic press_i,
    input wire logic hard_i,
    input wire logic takeover_i,
    input wire logic sleep_i,
    input wire logic drop_hold_i,
    output logic push_button_in_n_o,
    output logic push_button_hard_n_o,
    output logic power_hold_o,
    output logic hibernate_in_n_o,
    output logic rail_two_good_o
);
    logic [2:0] ramp_q;
    logic booted;
    // ======================================================
    // button: a hard press pulls the pin low as well
    assign push_button_in_n_o = !(press_i || hard_i);
    assign push_button_hard_n_o = !hard_i;
    // reset pin has a pull-up, so released oe reads high
    assign booted = !reset_oe_i;
    // rail two takes a few cycles to ramp to good
    assign rail_two_good_o = ramp_q[2];
    // ======================================================
    // processor: takes over only once out of reset, when takeover_i is set
    always_ff @(posedge mclk_i) begin
        ramp_q <= rst_i ? 3'h0 : {ramp_q[1:0], rail_en_i[1]};
        if (rst_i) begin
            power_hold_o <= 1'h0;
            hibernate_in_n_o <= 1'h0;
        end else begin
            if (takeover_i && booted) begin
                power_hold_o <= 1'h1;
                hibernate_in_n_o <= 1'h1;
            end
            if (sleep_i) begin
                hibernate_in_n_o <= 1'h0;
            end
            if (drop_hold_i) begin
                power_hold_o <= 1'h0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/pushbutton_power_mode_control_tb.sv */
// self-checking bench of the push-button power mode control block
`timescale 1ns/1ps
`default_nettype none
module pushbutton_power_mode_control_tb;
    localparam int T = 10;
    localparam logic [7:0] TMO = 8'h10;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat, r;
    logic ack, pbn, hardn, hold, hibn, good, rst_oe, st_oe, irq_oe;
    logic [6:0] rails;
    logic press = 1'h0, hard = 1'h0, take = 1'h0, sleep = 1'h0, drop = 1'h0, svl = 1'h0, flt = 1'h0;
    int checks = 0, miscompares = 0, n, tot;
    int seq_idx[4] = '{2, 0, 4, 7};
    int seq_ms[4] = '{2, 4, 8, 16};

    pushbutton_power_mode_control #(.TICK_CYCLES(T), .RESET_TIMEOUT_MS(TMO)) i_pushbutton_power_mode_control (
        .mclk_i(mclk), .rst_i(rst), .push_button_in_n_i(pbn), .push_button_hard_n_i(hardn),
        .power_hold_i(hold), .hibernate_in_n_i(hibn), .rail_two_good_i(good), .rail_fault_i(flt),
        .sys_voltage_low_i(svl), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rail_en_o(rails),
        .processor_reset_out_n_o(), .processor_reset_out_n_oe_o(rst_oe), .button_status_out_n_o(),
        .button_status_out_n_oe_o(st_oe), .interrupt_out_n_o(), .interrupt_out_n_oe_o(irq_oe));

    proc_button_model i_proc_button_model (
        .mclk_i(mclk), .rst_i(rst), .rail_en_i(rails), .reset_oe_i(rst_oe), .press_i(press),
        .hard_i(hard), .takeover_i(take), .sleep_i(sleep), .drop_hold_i(drop),
        .push_button_in_n_o(pbn), .push_button_hard_n_o(hardn), .power_hold_o(hold),
        .hibernate_in_n_o(hibn), .rail_two_good_o(good));

    // ======================================================
    // clock
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // ======================================================
    // tasks
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge mclk);
    endtask

    // classic single cycle; the request stands until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge mclk);
        while (ack !== 1'h1 && k < 20) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 20) begin
            miscompares++;
            $display("BAD %0t bus wait ran out", $time);
            summarize();
        end
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge mclk);
    endtask

    // bit 8 rail two good, bit 7 reset released, bits 6:0 rails
    task automatic wait_on(input int b, output int k);
        logic [8:0] v;
        k = 0;
        v = {good, !rst_oe, rails};
        while (v[b] !== 1'h1 && k < 3000) begin
            @(posedge mclk);
            k++;
            v = {good, !rst_oe, rails};
        end
        if (k >= 3000) begin
            miscompares++;
            $display("BAD %0t level wait ran out", $time);
            summarize();
        end
    endtask

    // ======================================================
    // sequence
    initial begin
        tick(2);
        rst <= 1'h0;
        tick(1);
        check(rails, 0, "rails at reset");
        check(rst_oe, 1, "reset at start");
        wb(1'h0, 8'h00, 0, r);
        check(r, 0, "ctrl masked");
        wb(1'h0, 8'h08, 0, r);
        check(r, 0, "unmapped read");
        $display("test reset done");
        press <= 1'h1;
        tick(3);
        check(rails[1], 1, "press starts");
        check(st_oe, 1, "status low");
        tick(5);
        press <= 1'h0;
        tick(4);
        check(rails, 0, "early release");
        check(st_oe, 0, "status released");
        $display("test early_release done");
        // let the rail two ramp model drain so the stale good level is not mistaken for a new one
        tick(4);
        take <= 1'h1;
        press <= 1'h1;
        wait_on(8, n);
        tick(3);
        check(rails[3], 1, "rail four on good");
        check(rst_oe, 1, "reset held");
        tot = 3;
        foreach (seq_idx[i]) begin
            wait_on(seq_idx[i], n);
            tot += n;
            check(tot >= (seq_ms[i] - 1) * T && tot <= seq_ms[i] * T + 4, 1, "seq timing");
        end
        tick(3);
        press <= 1'h0;
        tick(4);
        check(rails, 7'h1f, "normal");
        wb(1'h1, 8'h00, 32'h0000_0006, r);
        tick(2);
        check(rails, 7'h7f, "all on");
        $display("test boot done");
        for (int i = 0; i < 2; i++) begin
            svl <= (i == 0);
            flt <= (i == 1);
            tick(3);
            check(irq_oe, 0, "masked source");
            wb(1'h0, 8'h04, 0, r);
            check(r, (i == 0) ? 32'h0000_13ff : 32'h0000_16ff, "status validates source");
            wb(1'h1, 8'h00, 32'h0000_0006 | (32'h0000_0008 << i), r);
            tick(2);
            check(irq_oe, 1, "unmasked source");
            svl <= 1'h0;
            flt <= 1'h0;
            tick(3);
            check(irq_oe, 0, "source gone");
            wb(1'h1, 8'h00, 32'h0000_0006, r);
        end
        $display("test interrupt done");
        hard <= 1'h1;
        tick(3);
        check(rst_oe, 1, "manual reset");
        check(rails, 7'h7f, "press in run");
        tick(40);
        check(rst_oe, 1, "held while pressed");
        hard <= 1'h0;
        wait_on(7, n);
        check(n >= (TMO - 1) * T && n <= TMO * T + 4, 1, "reset timeout");
        $display("test manual_reset done");
        wb(1'h1, 8'h00, 32'h0000_0001, r);
        sleep <= 1'h1;
        tick(4);
        check(rails, 7'h01, "hibernate");
        drop <= 1'h1;
        tick(4);
        check(rails, 7'h01, "force keeps one");
        wb(1'h1, 8'h00, 32'h0000_0000, r);
        tick(4);
        check(rails, 7'h00, "all off");
        $display("test shutdown done");
        summarize();
    end
endmodule
`default_nettype wire
